// [rtl/adcs_pkg.sv]
// Purpose: shared constants for the converter control and display block
// Assumes: 16-bit host words, 100 MHz system clock
// Notes: status layout, display codes and converter timing
package adcs_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOLD_WINDOW_NS = 1000;
	localparam int HOLD_WINDOW_CYC = (HOLD_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_TIME_NS = 19000;
	localparam int CONV_TIME_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int ERR_BIT = 15;
	localparam int DUAL_BIT = 14;
	localparam int CHAN_HI = 13;
	localparam int CHAN_LO = 8;
	localparam int DONE_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int OVF_EN_BIT = 5;
	localparam int TRIG_EN_BIT = 4;
	localparam int DMA_HI = 3;
	localparam int DMA_LO = 1;
	localparam int START_BIT = 0;
	localparam int SEL_HI = 10;
	localparam int SEL_LO = 8;
	localparam int DP_BIT = 4;
	localparam int DIGITS = 6;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [11:0] RESULT_ZERO = 12'h800;
	localparam logic [3:0] GLYPH_TEST = 4'hA;
	localparam logic [3:0] GLYPH_MINUS = 4'hD;
	localparam logic [4:0] DIGIT_RESET = 5'h0F;
	localparam logic [7:0] SEG_BLANK = 8'h00;
	localparam logic [7:0] SEG_TEST = 8'hFF;
	localparam logic [7:0] SEG_MINUS = 8'h40;
endpackage

// [rtl/adcs_digit.sv]
// Purpose: one display digit latch with glyph decode
// Assumes: load strobe is one clock wide
// Notes: segments are gfedcba in bits 6..0, decimal point in bit 7
`timescale 1ns/1ps
`default_nettype none
module adcs_digit (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic load_i,
	input wire logic [4:0] code_i,
	output logic [7:0] seg_o
);
	logic [4:0] code_r;
	logic [6:0] glyph;
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			code_r <= adcs_pkg::DIGIT_RESET;
		else if (load_i)
			code_r <= code_i;
	end
	// Glyph table; unlisted codes blank
	always_comb
	begin
		case (code_r[3:0])
			4'h0: glyph = 7'h3F;
			4'h1: glyph = 7'h06;
			4'h2: glyph = 7'h5B;
			4'h3: glyph = 7'h4F;
			4'h4: glyph = 7'h66;
			4'h5: glyph = 7'h6D;
			4'h6: glyph = 7'h7D;
			4'h7: glyph = 7'h07;
			4'h8: glyph = 7'h7F;
			4'h9: glyph = 7'h6F;
			adcs_pkg::GLYPH_TEST: glyph = adcs_pkg::SEG_TEST[6:0];
			adcs_pkg::GLYPH_MINUS: glyph = adcs_pkg::SEG_MINUS[6:0];
			default: glyph = adcs_pkg::SEG_BLANK[6:0];
		endcase
	end
	assign seg_o = {code_r[adcs_pkg::DP_BIT], glyph};
endmodule
`default_nettype wire

// [rtl/adcs_ctrl.sv]
// Purpose: status register, result buffer and display loader of a converter
// Assumes: select/read/write strobes one clock wide, synchronous to clk_sys_i
// Notes: converter modelled by a cycle counter; result sampled from conv_data_i
// Summary of operation
// - Start request during an active conversion sets the error flag bit 15.
// - Completion while previous result unread sets the error flag.
// - Channel change within first microsecond of hold sets the error flag.
// - Error flag clears on any status write and on initialize; an error set in the same cycle wins over the write.
// - Bit 14 selects dual (1) or single (0) sample-and-hold.
// - Bits 13..8 pick the multiplexer channel.
// - Done bit 7 sets at completion; cleared by interrupt done or result read.
// - Bit 6 set lets done raise an interrupt request.
// - Bit 5 with clock present lets clock overflow start conversions.
// - Bit 4 with clock present lets trigger one start conversions.
// - Writing bit 0 starts a conversion; it clears at completion.
// - Reading data address returns 12-bit result right justified.
// - Result is offset binary, zero volts is octal 4000.
// - Data write loads a digit chosen by bits 10..8; bit 4 decimal point.
// - Two selects: status read/write with bytes, data read result, write display.
// - Interrupt only with enable set and DMA off; interrupt done clears done.
`timescale 1ns/1ps
`default_nettype none
module adcs_ctrl #(
	parameter int CONV_CYC = adcs_pkg::CONV_TIME_CYC,
	parameter int CHAN_W = 6
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic init_i,
	input wire logic sel_status_i,
	input wire logic sel_data_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [1:0] byte_en_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic ack_o,
	input wire logic clock_present_i,
	input wire logic clock_ovf_i,
	input wire logic trigger1_i,
	input wire logic [11:0] conv_data_i,
	input wire logic irq_done_i,
	output logic irq_req_o,
	output logic [CHAN_W-1:0] mux_chan_o,
	output logic dual_mode_o,
	output logic [2:0] dma_ctrl_o,
	output logic busy_o,
	output logic [8*adcs_pkg::DIGITS-1:0] seg_o
);
	typedef enum logic [1:0] {
		ADCS_IDLE = 2'b00,
		ADCS_HOLD = 2'b01,
		ADCS_CONV = 2'b10
	} adcs_state_e;

	localparam int CW = $clog2(CONV_CYC + adcs_pkg::HOLD_WINDOW_CYC + 2);

	adcs_state_e state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic err_r, dual_r, done_r, irq_en_r, ovf_en_r, trig_en_r, start_r, saved_r;
	logic [CHAN_W-1:0] chan_r;
	logic [2:0] dma_r;
	logic [11:0] result_r;
	logic [15:0] status_word;
	wire clr = !reset_n_i || init_i;
	wire st_wr = sel_status_i && wr_i;
	wire st_wr_lo = st_wr && byte_en_i[0];
	wire st_wr_hi = st_wr && byte_en_i[1];
	wire data_rd = sel_data_i && rd_i;
	wire data_wr = sel_data_i && wr_i;
	wire prog_start = st_wr_lo && wdata_i[adcs_pkg::START_BIT];
	wire ovf_start = ovf_en_r && clock_present_i && clock_ovf_i;
	wire trig_start = trig_en_r && clock_present_i && trigger1_i;
	wire start_req = prog_start || ovf_start || trig_start;
	wire active = state_r != ADCS_IDLE;
	wire finish = state_r == ADCS_CONV && cnt_r == CW'(CONV_CYC - 1);
	wire hold_early = state_r == ADCS_HOLD;
	wire chan_change = st_wr_hi && wdata_i[adcs_pkg::CHAN_HI:adcs_pkg::CHAN_LO] != chan_r;
	wire err_set = (start_req && active) || (finish && saved_r) || (chan_change && hold_early);
	wire dma_on = dma_r != 3'b000;

	// Hold window then conversion; a start while busy is refused, only flagged
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + CW'(1);
		case (state_r)
			ADCS_IDLE:
			begin
				cnt_nxt = '0;
				if (start_req)
					state_nxt = ADCS_HOLD;
			end
			ADCS_HOLD:
				if (cnt_r == CW'(adcs_pkg::HOLD_WINDOW_CYC - 1))
				begin
					state_nxt = ADCS_CONV;
					cnt_nxt = '0;
				end
			ADCS_CONV:
				if (finish)
				begin
					state_nxt = ADCS_IDLE;
					cnt_nxt = '0;
				end
			default:
			begin
				state_nxt = ADCS_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
		begin
			state_r <= ADCS_IDLE;
			cnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Error: set wins over a same-cycle status write
	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
			err_r <= 1'b0;
		else if (err_set)
			err_r <= 1'b1;
		else if (st_wr)
			err_r <= 1'b0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
		begin
			dual_r <= 1'b0;
			chan_r <= '0;
		end
		else if (st_wr_hi)
		begin
			dual_r <= wdata_i[adcs_pkg::DUAL_BIT];
			chan_r <= wdata_i[adcs_pkg::CHAN_HI:adcs_pkg::CHAN_LO];
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
		begin
			irq_en_r <= 1'b0;
			ovf_en_r <= 1'b0;
			trig_en_r <= 1'b0;
			dma_r <= 3'b000;
		end
		else if (st_wr_lo)
		begin
			irq_en_r <= wdata_i[adcs_pkg::IRQ_EN_BIT];
			ovf_en_r <= wdata_i[adcs_pkg::OVF_EN_BIT];
			trig_en_r <= wdata_i[adcs_pkg::TRIG_EN_BIT];
			dma_r <= wdata_i[adcs_pkg::DMA_HI:adcs_pkg::DMA_LO];
		end
	end

	// Start bit: stays set until the conversion completes or a low-byte status write loads bit 0 clear
	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
			start_r <= 1'b0;
		else if (finish)
			start_r <= 1'b0;
		else if (st_wr_lo)
			start_r <= wdata_i[adcs_pkg::START_BIT];
	end

	// Done and unread-result flags; completion wins over clears
	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
		begin
			done_r <= 1'b0;
			saved_r <= 1'b0;
			result_r <= adcs_pkg::RESULT_ZERO;
		end
		else if (finish)
		begin
			done_r <= 1'b1;
			saved_r <= 1'b1;
			result_r <= conv_data_i;
		end
		else
		begin
			if (data_rd || irq_done_i)
				done_r <= 1'b0;
			if (data_rd)
				saved_r <= 1'b0;
		end
	end

	assign status_word = {err_r, dual_r, chan_r, done_r, irq_en_r, ovf_en_r, trig_en_r,
		dma_r, start_r};
	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
			rdata_o <= adcs_pkg::STATUS_RESET;
		else if (sel_status_i && rd_i)
			rdata_o <= status_word;
		else if (data_rd)
			rdata_o <= {4'h0, result_r};
	end
	always_ff @(posedge clk_sys_i)
	begin
		if (clr)
			ack_o <= 1'b0;
		else
			ack_o <= sel_status_i || sel_data_i;
	end

	assign irq_req_o = done_r && irq_en_r && !dma_on;
	assign mux_chan_o = chan_r;
	assign dual_mode_o = dual_r;
	assign dma_ctrl_o = dma_r;
	assign busy_o = active;

	// Digit decode; codes 6 and 7 load nothing
	genvar gi;
	generate
		for (gi = 0; gi < adcs_pkg::DIGITS; gi++)
		begin : g_digit
			wire ld = data_wr && wdata_i[adcs_pkg::SEL_HI:adcs_pkg::SEL_LO] == 3'(gi);
			adcs_digit u_digit (
				.clk_sys_i(clk_sys_i),
				.reset_n_i(reset_n_i),
				.load_i(ld),
				.code_i(wdata_i[4:0]),
				.seg_o(seg_o[8*gi +: 8])
			);
		end
	endgenerate

	// Assertions
	property p_err_busy_start;
		@(posedge clk_sys_i) disable iff (clr)
		(start_req && active) |=> err_r;
	endproperty
	a_err_busy_start: assert property (p_err_busy_start) else $error("busy start no error");

	property p_err_overrun;
		@(posedge clk_sys_i) disable iff (clr)
		(finish && saved_r) |=> err_r;
	endproperty
	a_err_overrun: assert property (p_err_overrun) else $error("overrun no error");

	property p_err_chan;
		@(posedge clk_sys_i) disable iff (clr)
		(chan_change && hold_early) |=> err_r;
	endproperty
	a_err_chan: assert property (p_err_chan) else $error("channel change no error");

	property p_err_clear;
		@(posedge clk_sys_i) disable iff (clr)
		(st_wr && !err_set) |=> !err_r;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error not cleared");

	property p_done_set;
		@(posedge clk_sys_i) disable iff (clr)
		finish |=> done_r && !start_r && !active && result_r == $past(conv_data_i);
	endproperty
	a_done_set: assert property (p_done_set) else $error("completion effects wrong");

	property p_irq;
		@(posedge clk_sys_i) disable iff (clr)
		irq_req_o |-> (irq_en_r && done_r && dma_r == 3'b000);
	endproperty
	a_irq: assert property (p_irq) else $error("illegal interrupt");

	property p_read_clears;
		@(posedge clk_sys_i) disable iff (clr)
		(data_rd && !finish) |=> !done_r ##0 rdata_o == {4'h0, result_r};
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("result read wrong");

	// Own age count, so the length check does not lean on cnt_r
	logic [CW-1:0] conv_age_r;
	always_ff @(posedge clk_sys_i)
	begin
		if (clr || state_r != ADCS_CONV)
			conv_age_r <= '0;
		else
			conv_age_r <= conv_age_r + CW'(1);
	end
	property p_conv_len;
		@(posedge clk_sys_i) disable iff (clr)
		(state_r == ADCS_CONV) |-> (finish == (conv_age_r == CW'(CONV_CYC - 1)));
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	c_prog: cover property (@(posedge clk_sys_i) disable iff (clr) prog_start ##1 active);
	c_finish: cover property (@(posedge clk_sys_i) disable iff (clr) finish);
	c_irq: cover property (@(posedge clk_sys_i) disable iff (clr) irq_req_o ##1 irq_done_i);
	c_err: cover property (@(posedge clk_sys_i) disable iff (clr) $rose(err_r));
endmodule
`default_nettype wire

// [dv/adcs_host_model.sv]
// Purpose: bus controller side that completes device interrupts
// Assumes: interrupt request is a level, completion a one cycle pulse
// Notes: DLY sets how slowly it answers; en_i low leaves done to the program
`timescale 1ns/1ps
`default_nettype none
module adcs_host_model #(
	parameter int DLY = 3
) (
	input wire logic clk_sys_i,
	input wire logic en_i,
	input wire logic irq_req_i,
	output logic irq_done_o
);
	int cnt = 0;
	// One completion per request, never while the request is down
	always @(posedge clk_sys_i)
	begin
		irq_done_o <= 1'b0;
		cnt <= (en_i && irq_req_i) ? cnt + 1 : 0;
		if (en_i && irq_req_i && cnt == DLY)
		begin
			irq_done_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [dv/adcs_status_and_led_regs_tb_top.sv]
// Purpose: directed register tests of the converter control block
// Assumes: short conversion count, all driving 1 ns after the rising edge
// Notes: segment codes of numerals are not fixed, only lit or blank
`timescale 1ns/1ps
`default_nettype none
module adcs_status_and_led_regs_tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic init = 1'b0;
	logic sel_s = 1'b0;
	logic sel_d = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [1:0] be = 2'b00;
	logic [15:0] wdata = 16'h0000;
	logic present = 1'b0;
	logic ovf = 1'b0;
	logic trig = 1'b0;
	logic [11:0] conv = 12'h000;
	logic host_en = 1'b0;
	logic irq_done;
	logic irq_req;
	logic dual;
	logic busy;
	logic ack;
	logic [15:0] rdata;
	logic [5:0] chan;
	logic [2:0] dma;
	logic [47:0] seg;
	logic [47:0] seg_old;
	logic [3:0] glyph [7] = '{4'hA, 4'hD, 4'hB, 4'h8, 4'hC, 4'hE, 4'h3};
	int error_cnt = 0;
	int checks = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	adcs_ctrl #(.CONV_CYC(20)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.init_i(init), .sel_status_i(sel_s), .sel_data_i(sel_d), .rd_i(rd), .wr_i(wr),
		.byte_en_i(be), .wdata_i(wdata), .rdata_o(rdata), .ack_o(ack),
		.clock_present_i(present), .clock_ovf_i(ovf), .trigger1_i(trig),
		.conv_data_i(conv), .irq_done_i(irq_done), .irq_req_o(irq_req),
		.mux_chan_o(chan), .dual_mode_o(dual), .dma_ctrl_o(dma), .busy_o(busy),
		.seg_o(seg));
	adcs_host_model host_u (.clk_sys_i(clk_sys_i), .en_i(host_en), .irq_req_i(irq_req),
		.irq_done_o(irq_done));
	task automatic give_verdict();
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic bad(input string msg);
		error_cnt++;
		$display("Error at %0t: %s", $time, msg);
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp)
			bad($sformatf("got %0h expected %0h", got, exp));
	endtask
	task automatic step();
		@(posedge clk_sys_i);
		#1;
	endtask
	// Holds the strobes for exactly one taking edge, then waits for the ack;
	// one idle edge at the end keeps a next call from flipping a strobe at once
	task automatic acc(input logic s, input logic r, input logic [1:0] b, input logic [15:0] d);
		int n;
		sel_s = s;
		sel_d = !s;
		rd = r;
		wr = !r;
		be = b;
		wdata = d;
		step();
		sel_s = 1'b0;
		sel_d = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		n = 0;
		while (ack !== 1'b1 && n < 4)
		begin
			step();
			n++;
		end
		if (ack !== 1'b1)
		begin
			bad("no acknowledge");
			give_verdict();
		end
		step();
	endtask
	task automatic rd_s(input logic [15:0] e);
		acc(1'b1, 1'b1, 2'b11, 16'h0000);
		chk(rdata, e);
	endtask
	task automatic rd_d(input logic [15:0] e);
		acc(1'b0, 1'b1, 2'b11, 16'h0000);
		chk(rdata, e);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400)
		begin
			step();
			n++;
		end
		if (busy !== 1'b0)
		begin
			bad("conversion never ended");
			give_verdict();
		end
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		#1;
		reset_n_i = 1'b1;
		rd_s(16'h0000);
		acc(1'b1, 1'b0, 2'b11, 16'h4A00);
		acc(1'b1, 1'b0, 2'b01, 16'hFF00);
		rd_s(16'h4A00);
		chk({chan, dual, dma}, {6'h0A, 1'b1, 3'h0});
		acc(1'b1, 1'b0, 2'b11, 16'h0000);
		conv = 12'hFFF;
		host_en = 1'b1;
		acc(1'b1, 1'b0, 2'b11, 16'h0041);
		chk(busy, 1'b1);
		wait_idle();
		chk(irq_req, 1'b1);
		repeat (6) step();
		chk(irq_req, 1'b0);
		rd_s(16'h0040);
		rd_d(16'h0FFF);
		host_en = 1'b0;
		conv = 12'h800;
		acc(1'b1, 1'b0, 2'b11, 16'h0001);
		acc(1'b1, 1'b0, 2'b11, 16'h0001);
		rd_s(16'h8001);
		wait_idle();
		rd_s(16'h8080);
		acc(1'b1, 1'b0, 2'b10, 16'h0000);
		rd_s(16'h0080);
		acc(1'b1, 1'b0, 2'b01, 16'h004E);
		chk({irq_req, dma}, {1'b0, 3'h7});
		rd_s(16'h00CE);
		acc(1'b1, 1'b0, 2'b11, 16'h0001);
		wait_idle();
		rd_s(16'h8080);
		rd_d(16'h0800);
		rd_s(16'h8000);
		acc(1'b1, 1'b0, 2'b11, 16'h0001);
		acc(1'b1, 1'b0, 2'b10, 16'h0500);
		wait_idle();
		rd_s(16'h8580);
		rd_d(16'h0800);
		init = 1'b1;
		step();
		init = 1'b0;
		rd_s(16'h0000);
		// Overflow and trigger-one starts, each first with the clock unit absent, then present
		for (int i = 0; i < 2; i++)
		begin
			acc(1'b1, 1'b0, 2'b11, (i == 0) ? 16'h0020 : 16'h0010);
			for (int p = 0; p < 2; p++)
			begin
				present = p[0];
				ovf = (i == 0);
				trig = (i == 1);
				step();
				ovf = 1'b0;
				trig = 1'b0;
				chk(busy, p[0]);
				step();
			end
			wait_idle();
			rd_d(16'h0800);
		end
		for (int k = 0; k < 7; k++)
		begin
			seg_old = seg;
			acc(1'b0, 1'b0, 2'b11, {5'h00, 3'(k), 3'h0, 1'b1, glyph[k]});
			step();
			case (k)
				0: chk(seg[7:0], adcs_pkg::SEG_TEST | 8'h80);
				1: chk(seg[15:8], adcs_pkg::SEG_MINUS | 8'h80);
				3: chk({seg[31], seg[30:24] != 7'h00}, 2'b11);
				6: chk(seg, seg_old);
				default: chk(seg[8*k+:8], 8'h80);
			endcase
		end
		give_verdict();
	end
endmodule
`default_nettype wire
